// file: tb/pulse_sender.sv
`timescale 1ns/1ps
`default_nettype none
// Receiver output model: active-low pulses, idle high between frames
module pulse_sender (
  input wire logic i_core_clk,
  output var logic o_pulse_n
);
  initial o_pulse_n = 1'b1;

  // One frame of n pulses; gap stands in for the scaled channel width
  task automatic send_frame(input int n, input int gap, input bit glitch);
    for (int p = 0; p < n; p++) begin
      // Bounce on the first edge, to be swallowed by the hold-off
      if (glitch && p == 0) begin
        @(posedge i_core_clk) o_pulse_n <= 1'b0;
        @(posedge i_core_clk) o_pulse_n <= 1'b1;
      end
      @(posedge i_core_clk) o_pulse_n <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      o_pulse_n <= 1'b1;
      repeat (gap) @(posedge i_core_clk);
    end
  endtask : send_frame
endmodule : pulse_sender
`default_nettype wire

// file: tb/tb_pulse_train_channel_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch at %0t: got %h exp %h", $time, a, b); end end
module tb_pulse_train_channel_decoder
  import pulse_decoder_pkg::*;
;
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_clear_n = 1'b1;
  logic pulse_n;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [DATA_W-1:0] o_rdata;
  logic [N_STAGES-1:0] o_channel_pulse;
  logic o_shift_strobe;
  logic [N_STAGES-1:0] seen = '0;
  int n_fail = 0;
  int checked = 0;
  int k = 0;
  int n, gap;
  bit mon_on = 1'b0;
  bit clr_watch = 1'b0;
  bit fill_on = 1'b0;

  always #4 i_core_clk = ~i_core_clk;

  pulse_sender u_tx (.i_core_clk(i_core_clk), .o_pulse_n(pulse_n));

  // Short quiet time keeps the run small; all waits derive from 200
  pulse_train_channel_decoder #(.QUIET_DEFAULT(20'h000C8)) dut (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_pulse_train_n(pulse_n), .i_clear_n(i_clear_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_channel_pulse(o_channel_pulse), .o_shift_strobe(o_shift_strobe));

  // One-hot position expected after the k-th strobe of a frame
  function automatic logic [N_STAGES-1:0] exp_chan(input int k);
    return (k >= 1 && k <= 8) ? 8'h01 << (k - 1) : 8'h00;
  endfunction : exp_chan

  // Second set input held: stages one to k all high after k strobes
  function automatic logic [N_STAGES-1:0] exp_fill(input int k);
    return (k >= 8) ? 8'hFF : 8'((1 << k) - 1);
  endfunction : exp_fill

  task automatic report_and_stop;
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_core_clk) i_wr <= 1'b0;
  endtask : wr

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_core_clk) {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_core_clk) i_rd <= 1'b0;
    #1 `CHK(o_rdata, e)
  endtask : rd

  // Strobe watcher: checks the chain right after each shift lands
  always begin
    @(posedge i_core_clk);
    #1;
    if (o_shift_strobe === 1'b1) begin
      k++;
      if (mon_on) `CHK(o_channel_pulse, exp_chan(k))
      if (fill_on) `CHK(o_channel_pulse, exp_fill(k))
    end
    if (clr_watch) seen |= o_channel_pulse;
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge i_core_clk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    void'($urandom(23));
    repeat (5) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    `CHK(o_channel_pulse, 8'h00)
    rd(QUIET_OFS, 32'h0000_00C8);
    rd(STRETCH_OFS, 32'(STRETCH_RESET));
    rd(CTRL_OFS, 32'h0000_0000);
    rd(STATUS_OFS, 32'h0000_0100);
    wr(STATUS_OFS, 32'hFFFF_FFFF);
    rd(STATUS_OFS, 32'h0000_0100);
    rd(8'h10, 32'h0000_0000);
    wr(STRETCH_OFS, 32'h0000_0004);
    rd(STRETCH_OFS, 32'h0000_0004);
    // Pin clear, then soft clear, in the middle of a frame
    for (int c = 0; c < 2; c++) begin
      seen = '0;
      fork
        u_tx.send_frame(5, 60, 1'b0);
        begin
          repeat (150) @(posedge i_core_clk);
          if (c == 0) i_clear_n <= 1'b0;
          else wr(CTRL_OFS, 32'h0000_0002);
          repeat (6) @(posedge i_core_clk);
          clr_watch = 1'b1;
          repeat (94) @(posedge i_core_clk);
          if (c == 0) i_clear_n <= 1'b1;
          else wr(CTRL_OFS, 32'h0000_0000);
        end
      join
      repeat (260) @(posedge i_core_clk);
      clr_watch = 1'b0;
      `CHK(seen, 8'h00)
    end
    // Channel counts 2 to 9, random widths, some bouncing first edges
    for (int i = 0; i < 8; i++) begin
      n = i + 2;
      gap = 40 + $urandom % 100;
      k = 0;
      mon_on = 1'b1;
      u_tx.send_frame(n, gap, 1'($urandom % 2));
      repeat (260) @(posedge i_core_clk);
      mon_on = 1'b0;
      `CHK(k, n)
      `CHK(o_channel_pulse, 8'h00)
      rd(STATUS_OFS, (32'(n) << 9) | 32'h0000_0100);
    end
    // Shorter quiet time, then the second set input fills stages one to four
    wr(QUIET_OFS, 32'h0000_0096);
    rd(QUIET_OFS, 32'h0000_0096);
    wr(CTRL_OFS, 32'h0000_0001);
    rd(CTRL_OFS, 32'h0000_0001);
    k = 0;
    fill_on = 1'b1;
    u_tx.send_frame(4, 50, 1'b0);
    repeat (260) @(posedge i_core_clk);
    fill_on = 1'b0;
    `CHK(k, 4)
    `CHK(o_channel_pulse, 8'h00)
    wr(CTRL_OFS, 32'h0000_0000);
    rd(STATUS_OFS, 32'h0000_0900);
    report_and_stop();
  end
endmodule : tb_pulse_train_channel_decoder
`default_nettype wire

// file: verilog/level_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for pin inputs
module level_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  // First flop feeds only the second
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= RESET_VAL;
      o_sync <= RESET_VAL;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule : level_sync
`default_nettype wire

// file: verilog/pulse_decoder_pkg.sv
package pulse_decoder_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 125;
  // Quiet gap that ends a frame: above 2.0 ms channel maximum, below 4 ms pause
  localparam int QUIET_TIME_US = 3000;
  localparam int QUIET_CYCLES = QUIET_TIME_US * CLK_MHZ;
  // Strobe stretch; a least time, so rounded up to whole cycles
  localparam int STRETCH_TIME_NS = 1000;
  localparam int STRETCH_CYCLES = (STRETCH_TIME_NS * CLK_MHZ + 999) / 1000;

  // Widths
  localparam int N_STAGES = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int QUIET_W = 20;
  localparam int STRETCH_W = 8;
  localparam int CNT_W = 4;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] QUIET_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STRETCH_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0C;

  // Control field positions and reset value
  localparam int CTRL_SET_B_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [STRETCH_W-1:0] STRETCH_RESET = STRETCH_CYCLES[STRETCH_W-1:0];

  // Status word layout
  typedef struct packed {
    logic [18:0] zero;
    logic [CNT_W-1:0] strobes;
    logic set_level;
    logic [N_STAGES-1:0] chan;
  } status_t;
endpackage : pulse_decoder_pkg

// file: verilog/pulse_train_channel_decoder.sv
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pulse_train_channel_decoder
  import pulse_decoder_pkg::*;
#(
  parameter logic [QUIET_W-1:0] QUIET_DEFAULT = QUIET_CYCLES[QUIET_W-1:0]
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_pulse_train_n,
  input wire logic i_clear_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  output logic [N_STAGES-1:0] o_channel_pulse,
  output logic o_shift_strobe
);
  logic pulse_n_sync;
  logic clear_n_sync;
  logic pulse_lvl;
  logic pulse_lvl_q;
  logic shift_strobe;
  logic [STRETCH_W-1:0] holdoff_q;
  logic set_q;
  logic [QUIET_W-1:0] quiet_cnt_q;
  logic frame_end;
  logic [QUIET_W-1:0] quiet_q;
  logic [STRETCH_W-1:0] stretch_q;
  logic [1:0] ctrl_q;
  logic first_stage_set_a;
  logic first_stage_set_b;
  logic chain_clear_n;
  logic [N_STAGES-1:0] stage_q;
  logic [N_STAGES-1:0] stage_set;
  logic [CNT_W-1:0] strobe_cnt_q;
  logic [CNT_W-1:0] last_cnt_q;
  status_t status;
  logic set_b_trace_q;

  // Pins cross into the core clock before any logic looks at them
  level_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_pin_sync (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_async({i_pulse_train_n, i_clear_n}),
    .o_sync({pulse_n_sync, clear_n_sync})
  );

  // Receiver pulses are active low; work on the positive form
  assign pulse_lvl = ~pulse_n_sync;

  // Previous level for edge detection
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pulse_lvl_q <= 1'b0;
    end else begin
      pulse_lvl_q <= pulse_lvl;
    end
  end

  // One strobe per rising edge, then a hold-off that stretches it
  // Hold-off swallows ringing so one pulse never shifts twice
  assign shift_strobe = pulse_lvl & ~pulse_lvl_q & (holdoff_q == '0);

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      holdoff_q <= '0;
    end else if (shift_strobe) begin
      holdoff_q <= stretch_q;
    end else if (holdoff_q != '0) begin
      holdoff_q <= holdoff_q - 1'b1;
    end
  end

  // Visible strobe, registered copy of the internal one
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_shift_strobe <= 1'b0;
    end else begin
      o_shift_strobe <= shift_strobe;
    end
  end

  // Quiet timer: restarts on any pulse activity inside a frame
  assign frame_end = ~set_q & ~pulse_lvl & (quiet_cnt_q == quiet_q - 1'b1);

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      quiet_cnt_q <= '0;
    end else if (set_q || pulse_lvl || frame_end) begin
      quiet_cnt_q <= '0;
    end else begin
      quiet_cnt_q <= quiet_cnt_q + 1'b1;
    end
  end

  // Set level: high in the pause, dropped by the first strobe
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      set_q <= 1'b1;
    end else if (shift_strobe && set_q) begin
      set_q <= 1'b0;
    end else if (frame_end) begin
      set_q <= 1'b1;
    end
  end

  // Chain control
  assign first_stage_set_a = set_q;
  assign first_stage_set_b = ctrl_q[CTRL_SET_B_BIT];
  // End of frame wipes any leftover one so the pause reads all zero
  assign chain_clear_n = clear_n_sync & ~ctrl_q[CTRL_CLEAR_BIT]
                         & ~frame_end;
  assign stage_set = {stage_q[N_STAGES-2:0],
                      first_stage_set_a | first_stage_set_b};

  // Eight identical stages
  for (genvar g = 0; g < N_STAGES; g++) begin : g_stage
    rs_stage u_stage (
      .i_core_clk(i_core_clk),
      .i_resetn(i_resetn),
      .i_shift_strobe(shift_strobe),
      .i_set(stage_set[g]),
      .i_clear_n(chain_clear_n),
      .o_q(stage_q[g])
    );
  end

  assign o_channel_pulse = stage_q;

  // Strobes counted per frame, saturating; latched at frame end
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      strobe_cnt_q <= '0;
      last_cnt_q <= '0;
    end else if (frame_end) begin
      strobe_cnt_q <= '0;
      last_cnt_q <= strobe_cnt_q;
    end else if (shift_strobe && strobe_cnt_q != '1) begin
      strobe_cnt_q <= strobe_cnt_q + 1'b1;
    end
  end

  // Register writes
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      quiet_q <= QUIET_DEFAULT;
      stretch_q <= STRETCH_RESET;
      ctrl_q <= CTRL_RESET;
    end else if (i_wr) begin
      case (i_addr)
        QUIET_OFS: quiet_q <= i_wdata[QUIET_W-1:0];
        STRETCH_OFS: stretch_q <= i_wdata[STRETCH_W-1:0];
        CTRL_OFS: ctrl_q <= i_wdata[1:0];
        default: ;
      endcase
    end
  end

  // Status word
  always_comb begin
    status = '0;
    status.chan = stage_q;
    status.set_level = set_q;
    status.strobes = last_cnt_q;
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      case (i_addr)
        QUIET_OFS: o_rdata <= {{(DATA_W-QUIET_W){1'b0}}, quiet_q};
        STRETCH_OFS: o_rdata <= {{(DATA_W-STRETCH_W){1'b0}}, stretch_q};
        CTRL_OFS: o_rdata <= {30'h0, ctrl_q};
        STATUS_OFS: o_rdata <= status;
        default: o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  // Second set input can leave several ones until the chain empties
  // Set wins over the clear so a late write is never missed
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      set_b_trace_q <= 1'b0;
    end else if (first_stage_set_b) begin
      set_b_trace_q <= 1'b1;
    end else if (stage_q == '0 || !chain_clear_n) begin
      set_b_trace_q <= 1'b0;
    end
  end

  // Checks
  sequence s_first_strobe;
    shift_strobe && set_q;
  endsequence

  sequence s_loaded;
    stage_q[0] && !set_q;
  endsequence

  a_set_drops: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    s_first_strobe |=> !set_q)
    else $error("set level did not drop after first strobe");

  a_first_load: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    s_first_strobe ##0 chain_clear_n |=> s_loaded)
    else $error("first stage not loaded by first strobe");

  a_set_held_low: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    !set_q && !frame_end |=> !set_q)
    else $error("set level rose inside a frame");

  a_no_reload: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    shift_strobe && !set_q && !first_stage_set_b |=> !stage_q[0])
    else $error("first stage reloaded inside a frame");

  a_set_b_load: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    shift_strobe && first_stage_set_b && chain_clear_n |=> stage_q[0])
    else $error("second set input did not load first stage");

  a_chain_shift: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    shift_strobe && chain_clear_n
      |=> stage_q[N_STAGES-1:1] == $past(stage_q[N_STAGES-2:0]))
    else $error("chain did not shift by one stage");

  a_hold_no_strobe: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    !shift_strobe && chain_clear_n |=> $stable(stage_q))
    else $error("stage changed without a strobe");

  a_clear_forces: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    !chain_clear_n |=> stage_q == '0)
    else $error("clear did not empty the chain");

  a_pause_zero: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    frame_end |=> (stage_q == '0) && set_q)
    else $error("chain not empty and armed in pause");

  a_single_one: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    !first_stage_set_b && !set_b_trace_q |-> $onehot0(stage_q))
    else $error("more than one channel active");

  a_quiet_time: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    frame_end |-> $past(quiet_cnt_q) == quiet_q - 2'd2
      || quiet_q < 2'd2)
    else $error("frame ended before quiet time");

  a_strobe_stretch: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    shift_strobe |=> holdoff_q == $past(stretch_q))
    else $error("strobe not stretched by hold-off");

  a_strobe_single: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    shift_strobe |=> !shift_strobe)
    else $error("strobe longer than one cycle");

  a_input_invert: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    shift_strobe |-> !pulse_n_sync && $past(pulse_n_sync))
    else $error("strobe not from falling receiver edge");

  a_holdoff_blocks: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    holdoff_q != '0 |-> !shift_strobe)
    else $error("strobe issued inside hold-off");

  a_strobe_echo: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    shift_strobe |=> o_shift_strobe)
    else $error("visible strobe missing");

  a_pause_empty: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    set_q |-> stage_q == '0)
    else $error("chain not empty while armed");
endmodule : pulse_train_channel_decoder
`default_nettype wire

// file: verilog/rs_stage.sv
`timescale 1ns/1ps
`default_nettype none
// One set/clear shift stage
module rs_stage (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_shift_strobe,
  input wire logic i_set,
  input wire logic i_clear_n,
  output logic o_q
);
  // Clear dominates; otherwise a strobe copies the set input
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_q <= 1'b0;
    end else if (!i_clear_n) begin
      o_q <= 1'b0;
    end else if (i_shift_strobe) begin
      o_q <= i_set;
    end
  end
endmodule : rs_stage
`default_nettype wire
